// file: logic/pllcs_pkg.sv
// Constants shared by the loop controller control/status block.
// Assumes a 32-bit word register port with byte offsets on an 8-bit address.
package pllcs_pkg;

   // ************************************************************
   // Register port geometry
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Byte offsets of the two registers
   localparam logic [7:0] OFF_IDENTITY = 8'h00;
   localparam logic [7:0] OFF_CONTROL = 8'h04;

   // ************************************************************
   // Identity word fields
   // ************************************************************
   localparam int TYPE_LSB = 16;
   localparam int CLASS_LSB = 8;
   localparam int VERSION_LSB = 0;
   // Arbitrary neutral codes, to be replaced per product
   localparam logic [7:0] TYPE_CODE = 8'h5A;
   localparam logic [7:0] CLASS_CODE = 8'h3C;
   localparam logic [7:0] VERSION_CODE = 8'h07;

   // ************************************************************
   // Control/status fields and reset values
   // ************************************************************
   localparam int MODE_BIT = 0;
   localparam int PDN_BIT = 1;
   localparam int PRST_BIT = 3;
   localparam int STABLE_BIT = 6;
   localparam logic MODE_RESET = 1'b0;
   localparam logic PDN_RESET = 1'b0;
   localparam logic PRST_RESET = 1'b1;
   localparam logic STABLE_RESET = 1'b0;

   // ************************************************************
   // Timing counts, in reference clock cycles; the settle count is in clk_sys cycles
   // ************************************************************
   localparam int OSC_STABLE_CYCLES = 4096;
   localparam int DIRECT_STABLE_CYCLES = 512;
   localparam int STAB_W = 13;
   localparam logic [STAB_W-1:0] OSC_STABLE_LAST = STAB_W'(OSC_STABLE_CYCLES - 1);
   localparam logic [STAB_W-1:0] DIRECT_STABLE_LAST = STAB_W'(DIRECT_STABLE_CYCLES - 1);
   localparam int RESET_DIVIDE = 8;
   localparam int DIV_W = 3;
   // Cycles of clk_sys after release before the filtered strap is valid;
   // the synchroniser and filter need four edges, the strap is taken on the fifth
   localparam logic [2:0] SETTLE_LAST = 3'h4;

   // Reset controller phases
   typedef enum logic [1:0] {
      PH_SETTLE,
      PH_COUNT,
      PH_DONE
   } pllcs_phase_type;

endpackage

// file: logic/pllcs_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/1ns
module pllcs_sync #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Pins in, filtered levels out
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;
   logic [WIDTH-1:0] level_reg;
   logic [WIDTH-1:0] agree;
   logic [WIDTH-1:0] level_next;

   // A change is taken only when stages two and three agree
   assign agree = ~(stage2_reg ^ stage3_reg);
   assign level_next = (agree & stage3_reg) | (~agree & level_reg);
   assign level_out = level_reg;

   // Stage one is read by stage two only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
         level_reg <= '0;
      end else begin
         stage1_reg <= pin_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         level_reg <= level_next;
      end
   end

endmodule // pllcs_sync

// file: logic/pllcs_top.sv
// Control/status, identity and reset lengthening of the loop controller.
// Assumes reference clocks and the strap arrive as pins, slower than clk_sys/6.
//
// Summary of operation
// RULE1 - Software selects bypass before waking loop
// RULE2 - Software waits four slowest clock cycles
// RULE3 - Then software clears power-down bit
// RULE4 - Then software runs full loop reset sequence
// RULE5 - Identity read-only, type and class bytes
// RULE6 - Identity low byte version, top byte zero
// RULE7 - Stable set after 4096 or 512 cycles
// RULE8 - Stable reads zero while counting
// RULE9 - Control bits 31-7 read zero, ignored
// RULE10 - Bits 5-4 and 2 read zero
// RULE11 - Bit 3 drives loop reset
// RULE12 - Bit 1 drives loop power-down
// RULE13 - Mode zero feeds reference to dividers
// RULE14 - Mode one feeds multiplied clock path
// RULE15 - Software releases reset, waits lock, selects
// RULE16 - Outputs run reference/8 during internal reset
// RULE17 - Stable flag bit 6, read-only
// RULE18 - Stable cleared by reset, then sticky
`timescale 1ns/1ns
module pllcs_top
   import pllcs_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   // Reference and loop pins
   input wire logic crystal_oscillator_input,
   input wire logic direct_clock_input,
   input wire logic multiplied_clock_output,
   input wire logic reference_select_strap,
   // Loop control
   output logic loop_reset_out,
   output logic loop_power_down_out,
   output logic pre_divider_bypass,
   // Clock path and internal reset
   output logic divider_feed_clock,
   output logic internal_reset_n
);

   // ************************************************************
   // Helper functions
   // ************************************************************

   // Rising edge of a filtered level
   function automatic logic rise(input logic now_lvl, input logic old_lvl);
      rise = now_lvl & ~old_lvl;
   endfunction

   // Register decode
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // ************************************************************
   // Pin synchronisation
   // ************************************************************
   logic [3:0] pin_level;
   logic osc_lvl;
   logic direct_lvl;
   logic mult_lvl;
   logic strap_lvl;

   pllcs_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_in({reference_select_strap, multiplied_clock_output,
               direct_clock_input, crystal_oscillator_input}),
      .level_out(pin_level)
   );

   assign osc_lvl = pin_level[0];
   assign direct_lvl = pin_level[1];
   assign mult_lvl = pin_level[2];
   assign strap_lvl = pin_level[3];

   // ************************************************************
   // Reference selection and edge detection
   // ************************************************************
   logic strap_reg;
   logic ref_old_reg;
   logic ref_lvl;
   logic ref_edge;

   // Strap high picks the direct input, low the crystal input
   assign ref_lvl = strap_reg ? direct_lvl : osc_lvl;
   assign ref_edge = rise(ref_lvl, ref_old_reg);

   // ************************************************************
   // Reset controller
   // ************************************************************
   pllcs_phase_type phase_reg;
   pllcs_phase_type phase_next;
   logic [2:0] settle_reg;
   logic [STAB_W-1:0] stab_cnt_reg;
   logic [STAB_W-1:0] stab_last;
   logic stable_reg;
   logic count_done;

   assign stab_last = strap_reg ? DIRECT_STABLE_LAST : OSC_STABLE_LAST;
   assign count_done = ref_edge && (stab_cnt_reg == stab_last); // [RULE7]

   // Phase sequencing: settle the synchroniser, then count reference edges
   always_comb begin
      phase_next = phase_reg;
      unique case (phase_reg)
         PH_SETTLE: begin
            if (settle_reg == SETTLE_LAST) begin
               phase_next = PH_COUNT;
            end
         end
         PH_COUNT: begin
            if (count_done) begin
               phase_next = PH_DONE;
            end
         end
         PH_DONE: begin
            phase_next = PH_DONE;
         end
      endcase
   end

   // Strap is caught after release, once the synchroniser has settled
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= PH_SETTLE;
         settle_reg <= 3'h0;
         strap_reg <= 1'b0;
         ref_old_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         ref_old_reg <= ref_lvl;
         if (phase_reg == PH_SETTLE) begin
            settle_reg <= settle_reg + 3'h1;
            strap_reg <= strap_lvl;
         end
      end
   end

   // Stabilisation counter and sticky stable flag
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stab_cnt_reg <= '0;
         stable_reg <= STABLE_RESET; // [RULE18]
      end else begin
         if (phase_reg == PH_COUNT && ref_edge) begin
            stab_cnt_reg <= stab_cnt_reg + STAB_W'(1);
         end
         if (count_done) begin
            stable_reg <= 1'b1; // [RULE7] [RULE18]
         end
      end
   end

   assign internal_reset_n = stable_reg;

   // ************************************************************
   // Control register
   // ************************************************************
   logic mode_reg;
   logic pdn_reg;
   logic prst_reg;
   logic csr_write;

   assign csr_write = reg_write && hit(reg_addr, OFF_CONTROL);

   // Only bits 0, 1 and 3 are stored; stable and reserved bits ignore writes
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= MODE_RESET;
         pdn_reg <= PDN_RESET;
         prst_reg <= PRST_RESET;
      end else if (csr_write) begin
         mode_reg <= reg_wdata[MODE_BIT];
         pdn_reg <= reg_wdata[PDN_BIT];
         prst_reg <= reg_wdata[PRST_BIT];
      end
   end

   assign loop_reset_out = prst_reg; // [RULE11]
   assign loop_power_down_out = pdn_reg; // [RULE12]

   // ************************************************************
   // Read path
   // ************************************************************
   logic [DATA_W-1:0] id_word;
   logic [DATA_W-1:0] csr_word;
   logic [DATA_W-1:0] rdata_next;
   logic [DATA_W-1:0] rdata_reg;

   // Top byte of the identity word is constant zero
   assign id_word = {8'h00, TYPE_CODE, CLASS_CODE, VERSION_CODE}; // [RULE5] [RULE6]

   // Reserved bits are tied low, so only the documented fields show
   always_comb begin
      csr_word = '0; // [RULE9] [RULE10]
      csr_word[MODE_BIT] = mode_reg;
      csr_word[PDN_BIT] = pdn_reg;
      csr_word[PRST_BIT] = prst_reg;
      csr_word[STABLE_BIT] = stable_reg; // [RULE8] [RULE17]
   end

   // Unmapped reads return zero
   assign rdata_next = !reg_read ? '0 :
                       hit(reg_addr, OFF_IDENTITY) ? id_word :
                       hit(reg_addr, OFF_CONTROL) ? csr_word : '0;

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // ************************************************************
   // Clock path selection
   // ************************************************************
   logic [DIV_W-1:0] div8_reg;
   logic feed_next;
   logic feed_reg;
   logic use_loop;

   // Divide the reference by eight: msb toggles every four edges
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div8_reg <= '0;
      end else if (ref_edge) begin
         div8_reg <= div8_reg + DIV_W'(1); // [RULE16]
      end
   end

   // Loop path only with reset released and mode set; power-down does not gate it
   assign use_loop = stable_reg && mode_reg; // [RULE14]
   assign pre_divider_bypass = !use_loop; // [RULE13]
   // Sampled clocks are a model of the glitch-free mux, not a real clock tree
   assign feed_next = !stable_reg ? div8_reg[DIV_W-1] : // [RULE16]
                      use_loop ? mult_lvl : ref_lvl; // [RULE13] [RULE14]

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         feed_reg <= 1'b0;
      end else begin
         feed_reg <= feed_next;
      end
   end

   assign divider_feed_clock = feed_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   property p_id_read;
      @(posedge clk_sys) disable iff (!rst_n)
      reg_read && hit(reg_addr, OFF_IDENTITY) |=>
         reg_rdata[23:16] == TYPE_CODE && reg_rdata[15:8] == CLASS_CODE;
   endproperty
   a_id_read: assert property (p_id_read) else $error("identity fields wrong"); // [RULE5]

   property p_id_low_high;
      @(posedge clk_sys) disable iff (!rst_n)
      reg_read && hit(reg_addr, OFF_IDENTITY) |=>
         reg_rdata[31:24] == 8'h00 && reg_rdata[7:0] == VERSION_CODE;
   endproperty
   a_id_low_high: assert property (p_id_low_high) else $error("identity ends wrong"); // [RULE6]

   property p_stable_rise;
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(stable_reg) |-> $past(ref_edge) && $past(stab_cnt_reg) == $past(stab_last);
   endproperty
   a_stable_rise: assert property (p_stable_rise) else $error("stable set early"); // [RULE7]

   property p_stable_counting;
      @(posedge clk_sys) disable iff (!rst_n)
      reg_read && hit(reg_addr, OFF_CONTROL) && phase_reg != PH_DONE |=>
         reg_rdata[STABLE_BIT] == 1'b0;
   endproperty
   a_stable_counting: assert property (p_stable_counting) else $error("stable while counting"); // [RULE8]

   property p_csr_zeros;
      @(posedge clk_sys) disable iff (!rst_n)
      reg_read && hit(reg_addr, OFF_CONTROL) |=>
         reg_rdata[31:7] == 25'h0 && reg_rdata[5:4] == 2'h0 && reg_rdata[2] == 1'b0;
   endproperty
   a_csr_zeros: assert property (p_csr_zeros) else $error("reserved bits set"); // [RULE9] [RULE10]

   property p_loop_ctrl;
      @(posedge clk_sys) disable iff (!rst_n)
      csr_write |=> loop_reset_out == $past(reg_wdata[PRST_BIT]) &&
                    loop_power_down_out == $past(reg_wdata[PDN_BIT]);
   endproperty
   a_loop_ctrl: assert property (p_loop_ctrl) else $error("loop control lost"); // [RULE11] [RULE12]

   property p_path_select;
      @(posedge clk_sys) disable iff (!rst_n)
      stable_reg && $past(stable_reg) |-> pre_divider_bypass == !mode_reg &&
         divider_feed_clock == ($past(mode_reg) ? $past(mult_lvl) : $past(ref_lvl));
   endproperty
   a_path_select: assert property (p_path_select) else $error("path select wrong"); // [RULE13] [RULE14]

   property p_reset_div8;
      @(posedge clk_sys) disable iff (!rst_n)
      !stable_reg && !$past(stable_reg) && $past(rst_n) |->
         divider_feed_clock == $past(div8_reg[DIV_W-1]);
   endproperty
   a_reset_div8: assert property (p_reset_div8) else $error("reset clock not div8"); // [RULE16]

   property p_stable_ro;
      @(posedge clk_sys) disable iff (!rst_n)
      csr_write && !count_done |=> stable_reg == $past(stable_reg);
   endproperty
   a_stable_ro: assert property (p_stable_ro) else $error("stable written"); // [RULE17]

   property p_stable_sticky;
      @(posedge clk_sys) disable iff (!rst_n)
      stable_reg |=> stable_reg [*8];
   endproperty
   a_stable_sticky: assert property (p_stable_sticky) else $error("stable dropped"); // [RULE18]

endmodule // pllcs_top

// file: sim/pllcs_tb.sv
// Self-checking bench for the loop controller control/status block.
// Assumes the design's own assertions and the package constants of pllcs_pkg.
`timescale 1ns/1ns
module testbench;
   import pllcs_pkg::*;

   // ************************************************************
   // Stimulus and observed signals
   // ************************************************************
   logic clk_sys, rst_n, reg_write, reg_read;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
   logic crystal_oscillator_input, direct_clock_input;
   logic multiplied_clock_output, reference_select_strap;
   logic loop_reset_out, loop_power_down_out, pre_divider_bypass;
   logic divider_feed_clock, internal_reset_n, feed_prev;
   int n_errors, n_compared, feed_rises;

   pllcs_top u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .crystal_oscillator_input(crystal_oscillator_input),
      .direct_clock_input(direct_clock_input),
      .multiplied_clock_output(multiplied_clock_output),
      .reference_select_strap(reference_select_strap),
      .loop_reset_out(loop_reset_out), .loop_power_down_out(loop_power_down_out),
      .pre_divider_bypass(pre_divider_bypass), .divider_feed_clock(divider_feed_clock),
      .internal_reset_n(internal_reset_n)
   );

   // 100 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Count rises of the divider feed while the internal reset is still low
   always @(posedge clk_sys) begin
      feed_prev <= divider_feed_clock;
      if (rst_n && !internal_reset_n && divider_feed_clock && !feed_prev) feed_rises++;
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("Errors %0d, comparisons %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   // Slow reference: four clk_sys cycles high, four low, well under clk_sys/6
   task automatic ref_edges(input int n, input logic on_osc);
      repeat (n) begin
         @(posedge clk_sys);
         if (on_osc) begin
            crystal_oscillator_input <= 1'b1;
         end else begin
            direct_clock_input <= 1'b1;
         end
         repeat (4) @(posedge clk_sys);
         crystal_oscillator_input <= 1'b0;
         direct_clock_input <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
      #1;
   endtask

   task automatic do_reset;
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset_values;
      rd(OFF_CONTROL, 32'h00000008);
      chk(loop_reset_out, 1'b1);
      chk(loop_power_down_out, 1'b0);
      chk(pre_divider_bypass, 1'b1);
      chk(internal_reset_n, 1'b0);
   endtask

   // Identity ignores writes; unmapped places read as zero
   task automatic t_identity;
      wr(OFF_IDENTITY, 32'hFFFFFFFF);
      rd(OFF_IDENTITY, {8'h00, TYPE_CODE, CLASS_CODE, VERSION_CODE});
      @(posedge clk_sys);
      #1;
      chk(reg_rdata, 32'h00000000);
      rd(8'h08, 32'h00000000);
      rd(8'hFC, 32'h00000000);
   endtask

   // All ones written: only mode, power-down and loop reset stick
   task automatic t_control_bits;
      wr(OFF_CONTROL, 32'hFFFFFFFF);
      rd(OFF_CONTROL, 32'h0000000B);
      chk(loop_reset_out, 1'b1);
      chk(loop_power_down_out, 1'b1);
      chk(pre_divider_bypass, 1'b1);
      wr(OFF_CONTROL, 32'h00000000);
      chk(loop_reset_out, 1'b0);
      chk(loop_power_down_out, 1'b0);
      rd(OFF_CONTROL, 32'h00000000);
   endtask

   // Exactly 512 direct-input edges end the lengthened reset
   task automatic t_stabilize;
      feed_rises = 0;
      ref_edges(256, 1'b0);
      rd(OFF_CONTROL, 32'h00000000);
      ref_edges(255, 1'b0);
      repeat (8) @(posedge clk_sys);
      #1;
      chk(internal_reset_n, 1'b0);
      ref_edges(1, 1'b0);
      chk(internal_reset_n, 1'b1);
      rd(OFF_CONTROL, 32'h00000040);
      chk(feed_rises >= 63 && feed_rises <= 65, 1'b1);
   endtask

   // Path select follows the mode bit once out of reset
   task automatic t_mode_path;
      wr(OFF_CONTROL, 32'h00000001);
      chk(pre_divider_bypass, 1'b0);
      @(posedge clk_sys);
      multiplied_clock_output <= 1'b1;
      repeat (8) @(posedge clk_sys);
      #1;
      chk(divider_feed_clock, 1'b1);
      @(posedge clk_sys);
      multiplied_clock_output <= 1'b0;
      repeat (8) @(posedge clk_sys);
      #1;
      chk(divider_feed_clock, 1'b0);
      wr(OFF_CONTROL, 32'h00000000);
      chk(pre_divider_bypass, 1'b1);
      @(posedge clk_sys);
      multiplied_clock_output <= 1'b1;
      direct_clock_input <= 1'b1;
      repeat (8) @(posedge clk_sys);
      #1;
      chk(divider_feed_clock, 1'b1);
      @(posedge clk_sys);
      direct_clock_input <= 1'b0;
      repeat (8) @(posedge clk_sys);
      #1;
      chk(divider_feed_clock, 1'b0);
      rd(OFF_CONTROL, 32'h00000040);
   endtask

   // Power down, then wake in the documented order and return to loop mode
   task automatic t_wakeup;
      wr(OFF_CONTROL, 32'h00000002);
      chk(loop_power_down_out, 1'b1);
      wr(OFF_CONTROL, 32'h00000002);
      ref_edges(4, 1'b0);
      wr(OFF_CONTROL, 32'h00000000);
      chk(loop_power_down_out, 1'b0);
      wr(OFF_CONTROL, 32'h00000008);
      chk(loop_reset_out, 1'b1);
      ref_edges(4, 1'b0);
      wr(OFF_CONTROL, 32'h00000000);
      chk(loop_reset_out, 1'b0);
      ref_edges(4, 1'b0);
      wr(OFF_CONTROL, 32'h00000001);
      chk(pre_divider_bypass, 1'b0);
      rd(OFF_CONTROL, 32'h00000041);
   endtask

   // A second reset in mid-run clears the sticky stable flag
   task automatic t_second_reset;
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      chk(internal_reset_n, 1'b0);
      chk(pre_divider_bypass, 1'b1);
      rd(OFF_CONTROL, 32'h00000008);
   endtask

   // Strap low: only crystal edges count, and exactly 4096 end the reset
   task automatic t_crystal;
      @(posedge clk_sys);
      reference_select_strap <= 1'b0;
      do_reset();
      feed_rises = 0;
      repeat (8) @(posedge clk_sys);
      ref_edges(2048, 1'b1);
      rd(OFF_CONTROL, 32'h00000008);
      ref_edges(2047, 1'b1);
      ref_edges(4, 1'b0);
      chk(internal_reset_n, 1'b0);
      ref_edges(1, 1'b1);
      chk(internal_reset_n, 1'b1);
      rd(OFF_CONTROL, 32'h00000048);
      chk(feed_rises >= 511 && feed_rises <= 513, 1'b1);
   endtask

   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   initial begin
      rst_n = 1'b0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      crystal_oscillator_input = 1'b0;
      direct_clock_input = 1'b0;
      multiplied_clock_output = 1'b0;
      reference_select_strap = 1'b1;
      feed_prev = 1'b0;
      n_errors = 0;
      n_compared = 0;
      feed_rises = 0;
      do_reset();
      t_reset_values();
      t_identity();
      t_control_bits();
      t_stabilize();
      t_mode_path();
      t_wakeup();
      t_second_reset();
      t_crystal();
      close_out();
   end

   // Whole run needs about 37000 cycles, most of it the crystal count; allow margin
   initial begin
      #600000;
      n_errors++;
      close_out();
   end
endmodule // testbench
